// ---- src/ibp_cfg.svh ----
// ibp_cfg.svh: constants of the interleaved boost timing block
// assumes nothing; included by bare name
`ifndef IBP_CFG_SVH
`define IBP_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define IBP_CLK_HZ 60000000
`define IBP_COUNT_PS 16667
`define IBP_BOOST_PRD 300
`define IBP_RES_PRD 250
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IBP_OFS_CTRL 6'h00
`define IBP_OFS_DUTY 6'h04
`define IBP_OFS_INTC 6'h08
`define IBP_OFS_RESC 6'h0C
`define IBP_OFS_OVREF 6'h10
`define IBP_OFS_STAT 6'h14
`define IBP_OFS_CUR 6'h18
`define IBP_OFS_BUS 6'h1C
`define IBP_OFS_PAN 6'h20
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define IBP_RST_DUTY 9'h01E
`define IBP_RST_INTC 9'h050
`define IBP_RST_RESC 9'h07D
`define IBP_RST_OVREF 10'h328
`define IBP_CTRL_RUN 0
`endif

// ---- src/ibp_pkg.sv ----
// ibp_pkg: types of the interleaved boost timing block
// assumes ibp_cfg.svh is on the include path
package ibp_pkg;
  // avalon request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } ibp_av_req_t;
  // conversion slot of the sequence
  typedef enum logic [1:0] {
    IBP_SEQ_DUMMY = 2'b00,
    IBP_SEQ_CUR = 2'b01,
    IBP_SEQ_BUS = 2'b10,
    IBP_SEQ_PAN = 2'b11
  } ibp_seq_t;
  // whole state of the block
  typedef struct packed {
    logic run;
    logic [8:0] p1_cnt;
    logic p1_up;
    logic [8:0] p2_cnt;
    logic p2_up;
    logic [8:0] rs_cnt;
    logic rs_up;
    logic [8:0] duty_sh;
    logic [8:0] duty_act;
    logic [8:0] intc_sh;
    logic [8:0] intc_act;
    logic [8:0] rs_sh;
    logic [8:0] rs_act;
    logic [9:0] ov_code;
    logic [1:0] ov_sync;
    logic trip;
    logic w1;
    logic w2;
    logic wh;
    logic g1;
    logic g2;
    logic gh;
    logic gl;
    logic soc;
    logic busy;
    ibp_seq_t seq;
    logic irq_div;
    logic irq;
    logic [31:0] res_cur;
    logic [31:0] res_bus;
    logic [31:0] res_pan;
    logic waitreq;
    logic [31:0] rdata;
  } ibp_state_t;
endpackage

// ---- src/ibp_top.sv ----
// ibp_top: up-down time bases, gate drive, conversion trigger and
// overvoltage trip for an interleaved boost and a resonant half bridge
// assumes one 60 MHz clock, an on-chip adc sequencer on that clock and
// an analog comparator whose trip level arrives asynchronously
//
// Overview of operation
// (R01) boost time bases count up-down to 300, 600 counts per period
// (R02) resonant time base counts up-down to 250, 500 counts per period
// (R03) every counter steps once per 60 MHz clock cycle
// (R04) phase 1 gate clears on up-count match, sets on down-count match
// (R05) phase 2 gate behaves alike with its time base half a period later
// (R06) resonant timer drives the high-side and the low-side gate
// (R07) phase 1 counter zero issues one conversion start for the sequence
// (R08) a discarded dummy conversion precedes the measured channels
// (R09) current sampled at counter zero, the middle of the phase 1 on pulse
// (R10) current, bus, panel results rescaled from 12 bits to Q24
// (R11) control interrupt on phase 1 up-count match with compare B of 80
// (R12) control interrupt fires on every second match, 50 kHz
// (R13) compare writes go to shadows, loaded at the next counter zero
// (R14) software writes the duty compare from its Q24 duty each interrupt
// (R15) bus voltage compared with a 10-bit reference code, default 808
// (R16) overvoltage truncates the boost gates pulse by pulse
// (R17) only the boost gates are tripped, the resonant gates never
// (R18) trip state clears at each phase 1 counter zero where the synchronised overvoltage level is low
`include "ibp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module ibp_top #(
  parameter int BOOST_PRD = `IBP_BOOST_PRD,
  parameter int RES_PRD = `IBP_RES_PRD
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire ibp_pkg::ibp_av_req_t av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  // gate drive
  output logic boost_phase1_gate_o,
  output logic boost_phase2_gate_o,
  output logic resonant_high_gate_o,
  output logic resonant_low_gate_o,
  // adc sequencer
  output logic conversion_start_pulse_o,
  output logic [1:0] adc_channel_o,
  input wire logic adc_valid_i,
  input wire logic [11:0] adc_result_i,
  // control interrupt and overvoltage guard
  output logic control_interrupt_o,
  output logic [9:0] overvoltage_reference_code_o,
  input wire logic overvoltage_guard_i
);
  import ibp_pkg::*;

  localparam logic [8:0] BPRD = BOOST_PRD[8:0];
  localparam logic [8:0] RPRD = RES_PRD[8:0];
  localparam int COUNT_PS = `IBP_COUNT_PS; // one count of any time base

  ibp_state_t s;
  ibp_state_t next_s;
  logic p1_zero;
  logic av_hit;

  // --------------------------------------
  // helpers
  // --------------------------------------
  // one up-down step: returns {up, count}
  function automatic logic [9:0] ud_step(input logic [8:0] cnt, input logic up,
                                          input logic [8:0] prd);
    logic [8:0] n;
    n = up ? cnt + 9'h001 : cnt - 9'h001;
    if (up) begin
      return {(n != prd), n};
    end
    return {(n == 9'h000), n};
  endfunction

  // compare action: clear on up match, set on down match
  function automatic logic gate_act(input logic g, input logic [8:0] cnt,
                                    input logic up, input logic [8:0] cmp);
    if (cnt == cmp) begin
      return !up;
    end
    return g;
  endfunction

  // 12-bit result to Q24
  function automatic logic [31:0] to_q24(input logic [11:0] r);
    return {8'h00, r, 12'h000};
  endfunction

  // --------------------------------------
  // next state
  // --------------------------------------
  always_comb begin
    next_s = s;
    p1_zero = 1'b0;
    av_hit = 1'b0;
    // time bases advance every clock while running
    if (s.run) begin
      {next_s.p1_up, next_s.p1_cnt} = ud_step(s.p1_cnt, s.p1_up, BPRD); // R01 R03
      {next_s.p2_up, next_s.p2_cnt} = ud_step(s.p2_cnt, s.p2_up, BPRD); // R05
      {next_s.rs_up, next_s.rs_cnt} = ud_step(s.rs_cnt, s.rs_up, RPRD); // R02
      p1_zero = (next_s.p1_cnt == 9'h000);
      // waveform of each gate before trip
      next_s.w1 = gate_act(s.w1, s.p1_cnt, s.p1_up, s.duty_act); // R04
      next_s.w2 = gate_act(s.w2, s.p2_cnt, s.p2_up, s.duty_act); // R05
      next_s.wh = gate_act(s.wh, s.rs_cnt, s.rs_up, s.rs_act); // R06
      // control interrupt on every second up-count match
      next_s.irq = 1'b0;
      if (s.p1_up && s.p1_cnt == s.intc_act) begin
        next_s.irq_div = !s.irq_div; // R12
        next_s.irq = s.irq_div; // R11 R12
      end
      // resonant shadow loads at its own zero
      if (next_s.rs_cnt == 9'h000) begin
        next_s.rs_act = s.rs_sh; // R13
      end
    end else begin
      // stopped: phase 2 waits half a period ahead
      next_s.p1_cnt = 9'h000;
      next_s.p1_up = 1'b1;
      next_s.p2_cnt = BPRD; // R05
      next_s.p2_up = 1'b0;
      next_s.rs_cnt = 9'h000;
      next_s.rs_up = 1'b1;
      next_s.w1 = 1'b0;
      next_s.w2 = 1'b0;
      next_s.wh = 1'b0;
      next_s.irq = 1'b0;
      next_s.irq_div = 1'b0;
    end
    // shadows to active compares at phase 1 zero
    if (p1_zero) begin
      next_s.duty_act = s.duty_sh; // R13
      next_s.intc_act = s.intc_sh; // R13
    end
    // conversion start at phase 1 zero, dummy slot first
    next_s.soc = p1_zero; // R07 R09
    if (p1_zero) begin
      next_s.busy = 1'b1;
      next_s.seq = IBP_SEQ_DUMMY; // R08
    end else if (s.busy && adc_valid_i) begin
      case (s.seq)
        IBP_SEQ_DUMMY: begin
          next_s.seq = IBP_SEQ_CUR; // R08
        end
        IBP_SEQ_CUR: begin
          next_s.res_cur = to_q24(adc_result_i); // R10
          next_s.seq = IBP_SEQ_BUS;
        end
        IBP_SEQ_BUS: begin
          next_s.res_bus = to_q24(adc_result_i); // R10
          next_s.seq = IBP_SEQ_PAN;
        end
        IBP_SEQ_PAN: begin
          next_s.res_pan = to_q24(adc_result_i); // R10
          next_s.busy = 1'b0;
        end
        default: begin
          next_s.busy = 1'b0;
        end
      endcase
    end
    // overvoltage level passes two flops; set wins over the zero clear
    next_s.ov_sync = {s.ov_sync[0], overvoltage_guard_i};
    if (s.ov_sync[1]) begin
      next_s.trip = 1'b1; // R15 R16
    end else if (p1_zero) begin
      next_s.trip = 1'b0; // R18
    end
    // boost gates truncated by the trip, resonant gates untouched
    next_s.g1 = next_s.w1 && !next_s.trip; // R16
    next_s.g2 = next_s.w2 && !next_s.trip; // R16
    next_s.gh = next_s.wh; // R06 R17
    next_s.gl = s.run && !next_s.wh; // R06 R17
    // avalon: one wait cycle, then answer for one cycle
    next_s.waitreq = 1'b1;
    if ((av_req_i.read || av_req_i.write) && s.waitreq) begin
      av_hit = 1'b1;
      next_s.waitreq = 1'b0;
    end
    if (av_hit && av_req_i.read) begin
      case (av_req_i.address)
        `IBP_OFS_CTRL: next_s.rdata = {31'h0, s.run};
        `IBP_OFS_DUTY: next_s.rdata = {23'h0, s.duty_sh};
        `IBP_OFS_INTC: next_s.rdata = {23'h0, s.intc_sh};
        `IBP_OFS_RESC: next_s.rdata = {23'h0, s.rs_sh};
        `IBP_OFS_OVREF: next_s.rdata = {22'h0, s.ov_code};
        `IBP_OFS_STAT: next_s.rdata = {16'h0, s.busy, s.ov_sync[1], s.trip, s.irq_div,
                                       2'h0, s.p1_up, s.p1_cnt};
        `IBP_OFS_CUR: next_s.rdata = s.res_cur;
        `IBP_OFS_BUS: next_s.rdata = s.res_bus;
        `IBP_OFS_PAN: next_s.rdata = s.res_pan;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (av_hit && av_req_i.write) begin
      case (av_req_i.address)
        `IBP_OFS_CTRL: next_s.run = av_req_i.writedata[`IBP_CTRL_RUN];
        `IBP_OFS_DUTY: next_s.duty_sh = av_req_i.writedata[8:0]; // R13 R14
        `IBP_OFS_INTC: next_s.intc_sh = av_req_i.writedata[8:0]; // R13
        `IBP_OFS_RESC: next_s.rs_sh = av_req_i.writedata[8:0]; // R13
        `IBP_OFS_OVREF: next_s.ov_code = av_req_i.writedata[9:0]; // R15
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------
  // state register
  // --------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.p1_up <= 1'b1;
      s.p2_cnt <= BPRD;
      s.rs_up <= 1'b1;
      s.duty_sh <= `IBP_RST_DUTY;
      s.duty_act <= `IBP_RST_DUTY;
      s.intc_sh <= `IBP_RST_INTC; // R11
      s.intc_act <= `IBP_RST_INTC;
      s.rs_sh <= `IBP_RST_RESC;
      s.rs_act <= `IBP_RST_RESC;
      s.ov_code <= `IBP_RST_OVREF; // R15
      s.waitreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------
  // outputs, all from flops
  // --------------------------------------
  assign av_readdata_o = s.rdata;
  assign av_waitrequest_o = s.waitreq;
  assign boost_phase1_gate_o = s.g1;
  assign boost_phase2_gate_o = s.g2;
  assign resonant_high_gate_o = s.gh;
  assign resonant_low_gate_o = s.gl;
  assign conversion_start_pulse_o = s.soc;
  assign adc_channel_o = s.seq;
  assign control_interrupt_o = s.irq;
  assign overvoltage_reference_code_o = s.ov_code;

endmodule // ibp_top
`default_nettype wire

// ---- testbench/ibp_monitor.sv ----
// ibp_monitor: timing checks on the ports of ibp_top
// assumes the run bit stays set once written
`timescale 1ns/1ns
`default_nettype none
module ibp_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic boost_phase1_gate_o,
  input wire logic boost_phase2_gate_o,
  input wire logic resonant_high_gate_o,
  input wire logic resonant_low_gate_o,
  input wire logic conversion_start_pulse_o,
  input wire logic control_interrupt_o,
  input wire logic [9:0] overvoltage_reference_code_o,
  input wire logic overvoltage_guard_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [10:0] quiet;
  logic [10:0] gap;
  logic seen;
  logic [1:0] socs;
  logic [10:0] soc_gap;
  logic [10:0] rs_gap;
  logic rh_q;
  logic rs_seen;
  logic rh_rise;
  // rising edge of the resonant high gate, idle level low
  assign rh_rise = resonant_high_gate_o && !rh_q;
  // cycles since overvoltage and since interrupt, starts seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet <= '0;
      gap <= '0;
      seen <= 1'b0;
      socs <= '0;
      soc_gap <= '0;
      rs_gap <= '0;
      rh_q <= 1'b0;
      rs_seen <= 1'b0;
    end else begin
      soc_gap <= conversion_start_pulse_o ? 11'h000 : soc_gap + 11'(soc_gap != 11'h7FF);
      rs_gap <= rh_rise ? 11'h000 : rs_gap + 11'(rs_gap != 11'h7FF);
      rh_q <= resonant_high_gate_o;
      rs_seen <= rs_seen | rh_rise;
      quiet <= overvoltage_guard_i ? 11'h000 : quiet + 11'(quiet != 11'h7FF);
      gap <= control_interrupt_o ? 11'h000 : gap + 11'(gap != 11'h7FF);
      seen <= seen | control_interrupt_o;
      socs <= socs + 2'(conversion_start_pulse_o && socs != 2'h3);
    end
  end
  soc_period_a: assert property (conversion_start_pulse_o && socs != 2'h0 |-> soc_gap == 11'h257)
    else $error("start spacing wrong");
  irq_place_a: assert property (control_interrupt_o |-> $past(conversion_start_pulse_o, 81))
    else $error("interrupt offset wrong");
  irq_rate_a: assert property (control_interrupt_o && seen |-> gap == 11'h4AF)
    else $error("interrupt spacing wrong");
  gate_clear_a: assert property (conversion_start_pulse_o |-> ##300 !boost_phase1_gate_o)
    else $error("gate1 high at period top");
  gate_resume_a: assert property (conversion_start_pulse_o && socs == 2'h3 && quiet > 11'h2BC |-> boost_phase1_gate_o)
    else $error("gate1 not resumed");
  res_period_a: assert property (rh_rise && rs_seen |-> rs_gap == 11'h1F3)
    else $error("resonant period wrong");
  gate_pair_a: assert property ($changed(resonant_high_gate_o) |-> resonant_low_gate_o == !resonant_high_gate_o)
    else $error("resonant pair wrong");
  trip_force_a: assert property (overvoltage_guard_i [*5] |-> !boost_phase1_gate_o && !boost_phase2_gate_o)
    else $error("boost gate on in trip");
  ref_default_a: assert property ($rose(rst_n_i) |-> overvoltage_reference_code_o == 10'h328)
    else $error("reference code wrong");
  cover property (control_interrupt_o && seen);
  cover property (overvoltage_guard_i [*5]);
  cover property ($rose(boost_phase2_gate_o));
endmodule // ibp_monitor
bind ibp_top ibp_monitor u_mon (.clk_i, .rst_n_i, .boost_phase1_gate_o, .boost_phase2_gate_o,
  .resonant_high_gate_o, .resonant_low_gate_o, .conversion_start_pulse_o,
  .control_interrupt_o, .overvoltage_reference_code_o, .overvoltage_guard_i);
`default_nettype wire

// ---- testbench/ibp_adc_model.sv ----
// ibp_adc_model: converter sequencer answering each conversion start
// assumes the channel input names the slot being converted
`timescale 1ns/1ns
`default_nettype none
module ibp_adc_model #(
  parameter int DLY = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sequencer side
  input wire logic soc_i,
  input wire logic [1:0] chan_i,
  output logic valid_o,
  output logic [11:0] result_o
);
  int left;
  int dly;
  // four conversions per start, dummy slot first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 0;
      dly <= 0;
      valid_o <= 1'b0;
      result_o <= 12'h000;
    end else begin
      valid_o <= 1'b0;
      result_o <= ~result_o; // stale data inverted every cycle, never held
      if (soc_i) begin
        left <= 4;
        dly <= DLY;
      end else if (dly > 0) begin
        dly <= dly - 1;
      end else if (left > 0) begin
        valid_o <= 1'b1;
        result_o <= 12'h5A0 + 12'(chan_i);
        left <= left - 1;
        dly <= DLY;
      end
    end
  end
endmodule // ibp_adc_model
`default_nettype wire

// ---- testbench/tb_interleaved_boost_pwm_adc_timing.sv ----
// tb_interleaved_boost_pwm_adc_timing: directed bench for ibp_top
// assumes ibp_adc_model as converter and ibp_monitor bound in
`timescale 1ns/1ns
`default_nettype none
module tb_interleaved_boost_pwm_adc_timing;
  import ibp_pkg::*;
  localparam logic [5:0] ADR [5] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h24};
  localparam logic [31:0] RST [5] = '{32'h1E, 32'h50, 32'h7D, 32'h328, 32'h0};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ibp_av_req_t req = '0;
  logic guard = 1'b0;
  logic [31:0] rd, q;
  logic wait_o, g1, g2, rh, rl, soc, irq, vld;
  logic [1:0] chan;
  logic [11:0] res;
  logic [9:0] ovc;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n, m;
  initial forever #5 clk_i = ~clk_i;
  ibp_top DUT (.clk_i, .rst_n_i, .av_req_i(req), .av_readdata_o(rd), .av_waitrequest_o(wait_o),
    .boost_phase1_gate_o(g1), .boost_phase2_gate_o(g2), .resonant_high_gate_o(rh),
    .resonant_low_gate_o(rl), .conversion_start_pulse_o(soc), .adc_channel_o(chan),
    .adc_valid_i(vld), .adc_result_i(res), .control_interrupt_o(irq),
    .overvoltage_reference_code_o(ovc), .overvoltage_guard_i(guard));
  ibp_adc_model ADC (.clk_i, .rst_n_i, .soc_i(soc), .chan_i(chan), .valid_o(vld),
    .result_o(res));
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    req <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk_i); while (wait_o !== 1'b0);
    q = rd;
    req <= '0;
    @(posedge clk_i);
  endtask
  // cycles until an event: 0 start, 1 gate1 low, 2 gate2 high, 3/4 resonant, 5 irq
  task automatic wait_on(input int k, output int c);
    logic [5:0] v;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
      v = {irq, !rh, rh, g2, !g1, soc};
    end while (v[k] !== 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ADR[i], '0);
      chk("reset read", RST[i], q);
    end
    chk("reference code", 32'h328, {22'h0, ovc});
    bus(1'b1, 6'h00, 32'h1);
    wait_on(0, n);
    wait_on(0, n);
    wait_on(1, n);
    chk("gate1 clear", 32'h1F, n);
    wait_on(2, m);
    chk("gate2 set", 32'h10F, n + m);
    wait_on(5, n);
    wait_on(5, n);
    chk("irq spacing", 32'h4B0, n);
    wait_on(0, n);
    chk("irq to start", 32'h207, n);
    for (int i = 1; i < 4; i++) begin
      bus(1'b0, 6'h14 + 6'(4 * i), '0);
      chk("result", {8'h00, 12'h5A0 + 12'(i), 12'h000}, q);
    end
    wait_on(4, n);
    wait_on(3, n);
    wait_on(4, n);
    wait_on(3, m);
    chk("resonant period", 32'h1F4, n + m);
    // duty written just after a start stays in the shadow
    wait_on(0, n);
    bus(1'b1, 6'h04, 32'h3C);
    bus(1'b0, 6'h04, '0);
    chk("duty shadow", 32'h3C, q);
    wait_on(1, n);
    wait_on(0, n);
    chk("old duty", 32'h239, n);
    wait_on(1, n);
    chk("new duty", 32'h3D, n);
    // overvoltage burst near the top of a period
    wait_on(0, n);
    repeat (250) @(posedge clk_i);
    guard <= 1'b1;
    repeat (10) @(posedge clk_i);
    guard <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk("gate2 tripped", 32'h0, {31'h0, g2});
    wait_on(0, n);
    wait_on(0, n);
    chk("gate1 resumed", 32'h1, {31'h0, g1});
    summarize();
  end
endmodule // tb_interleaved_boost_pwm_adc_timing
`default_nettype wire
